/* File: qpdbi_cfg.svh */
`ifndef QPDBI_CFG_SVH
`define QPDBI_CFG_SVH

// ----------------------------------------------------------------
// Widths and grouping
// ----------------------------------------------------------------
`define QPDBI_DATA_W 64
`define QPDBI_GROUP_W 16
`define QPDBI_GROUPS 4
`define QPDBI_HALF_W 8
`define QPDBI_SLOTS 4
`define QPDBI_FIFO_DEPTH 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QPDBI_BUSCLK_NS 48
`define QPDBI_CLK_NS 4
`define QPDBI_SLOT_CYC ((`QPDBI_BUSCLK_NS / `QPDBI_CLK_NS) / `QPDBI_SLOTS)
`define QPDBI_HOLD_CYC (`QPDBI_SLOT_CYC - 2)

`endif

/* File: qpdbi_far_agent.sv */
// ----------------------------------------------------------------
// Far bus agent driving data words toward the block
// ----------------------------------------------------------------
module qpdbi_far_agent;
    timeunit 1ns;
    timeprecision 100ps;

    qpdbi_pkg::qpdbi_pins_t drv;
    logic useN;

    // Released lines rest at the termination level, all ones, never at the last value.
    initial begin
        drv = '1;
        useN = 1'b0;
    end

    function automatic logic [63:0] enc(input logic [63:0] d, input logic [3:0] flagPin);
        logic [63:0] p;
        for (int g = 0; g < 4; g++) begin
            p[16*g +: 16] = flagPin[g] ? ~d[16*g +: 16] : d[16*g +: 16];
        end
        return p;
    endfunction

    // Data is held 12 ns on each side of the strobe fall, three clock cycles of margin.
    task automatic send(input logic [63:0] d, input logic [3:0] flagPin, input logic validPin);
        drv.data = enc(d, flagPin);
        drv.invFlag = flagPin;
        drv.valid = validPin;
        #12;
        if (useN) begin
            drv.strbN = 4'h0;
        end else begin
            drv.strbP = 4'h0;
        end
        #12;
        drv.strbP = 4'hf;
        drv.strbN = 4'hf;
        useN = ~useN;
    endtask

    task automatic release_bus();
        drv = '1;
    endtask
endmodule // qpdbi_far_agent

/* File: qpdbi_fifo.sv */
`include "qpdbi_cfg.svh"

module qpdbi_fifo #(
    parameter int W = `QPDBI_DATA_W,
    parameter int DEPTH = `QPDBI_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);

    localparam int AW = $clog2(DEPTH);

    // DEPTH must be a power of two so that the pointers wrap by themselves.
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic inReady;
        logic outValid;
        logic [W-1:0] head;
    } qpdbi_fifo_state_t;

    qpdbi_fifo_state_t r_reg;
    qpdbi_fifo_state_t r_next;
    logic push;
    logic pop;

    assign push = inValid & r_reg.inReady;
    assign pop = outReady & r_reg.outValid;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_reg.wp] = inData;
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        r_next.inReady = r_next.cnt != (AW+1)'(DEPTH);
        r_next.outValid = r_next.cnt != '0;
        // The head word is registered so the consumer never sees a memory read path.
        r_next.head = r_next.mem[r_next.rp];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign inReady = r_reg.inReady;
    assign outValid = r_reg.outValid;
    assign outData = r_reg.head;

endmodule // qpdbi_fifo

/* File: qpdbi_link.sv */
// Function
// R1: Payload travels over one shared 64-bit data path common to all agents.
// R2: The driver asserts the valid indicator on each real transfer and receivers take only marked words.
// R3: The driver places four successive words on the data lines in every common bus clock period.
// R4: Receivers latch on the falling edge of the positive-phase and of the negative-phase strobe.
// R5: Data lines form groups of sixteen, each timed by its own strobe pair from the driver.
// R6: Group n covers bits 16n+15 down to 16n and uses strobe pair n and inversion flag n.
// R7: A receiver complements a group whose inversion flag is asserted to restore the true data.
// R8: A driver may invert a group when more than half of its bits would be asserted.
// R9: The inversion flag is asserted exactly when its group is driven inverted.
// R10: The inversion decision is made anew for each of the four transfers of a period.
`include "qpdbi_cfg.svh"

module qpdbi_link #(
    parameter int FIFO_DEPTH = `QPDBI_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic busClk,
    input wire logic busOwner,
    input wire logic txValid,
    input wire logic [`QPDBI_DATA_W-1:0] txData,
    output logic txReady,
    input wire qpdbi_pkg::qpdbi_pins_t pinsIn,
    output qpdbi_pkg::qpdbi_pins_t pinsOut,
    output logic pinsOeN,
    output logic [`QPDBI_DATA_W-1:0] rxWord,
    output logic rxValid
);

    localparam int GW = `QPDBI_GROUP_W;
    localparam int NG = `QPDBI_GROUPS;
    localparam int SC = `QPDBI_SLOT_CYC;

    qpdbi_pkg::qpdbi_state_t r_reg;
    qpdbi_pkg::qpdbi_state_t r_next;

    logic fifoValid;
    logic fifoPop;
    logic [`QPDBI_DATA_W-1:0] fifoData;
    logic [`QPDBI_DATA_W-1:0] txPins;
    logic [NG-1:0] txInv;
    logic [NG-1:0] rxLatch;
    logic [`QPDBI_DATA_W-1:0] rxTrue;
    logic [`QPDBI_DATA_W-1:0] latchMask;
    logic [`QPDBI_DATA_W-1:0] txDecoded;
    logic [NG-1:0] gotNext;
    logic busRise;
    logic rxArmed;
    logic startSlot;

    // ----------------------------------------------------------------
    // Transmit buffer
    // ----------------------------------------------------------------
    qpdbi_fifo #(
        .W(`QPDBI_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(txValid),
        .inData(txData),
        .inReady(txReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(fifoPop)
    );

    // ----------------------------------------------------------------
    // Per-group coding
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NG; g++) begin : gen_group
        localparam int LO = g * GW;
        // The decision is taken on the word about to leave, so each word gets its own flag.
        assign txInv[g] = $countones(fifoData[LO +: GW]) > `QPDBI_HALF_W; // [R8] [R10]
        // Pin level is the complement of the logical value; inversion undoes that.
        assign txPins[LO +: GW] = txInv[g] ? fifoData[LO +: GW] : ~fifoData[LO +: GW]; // [R6]
        assign rxTrue[LO +: GW] = r_reg.inS2.invFlag[g] ? ~r_reg.inS2.data[LO +: GW]
                                                        : r_reg.inS2.data[LO +: GW]; // [R7]
        assign rxLatch[g] = rxArmed & ~r_reg.inS2.valid
                            & ((r_reg.prevP[g] & ~r_reg.inS2.strbP[g])
                            | (r_reg.prevN[g] & ~r_reg.inS2.strbN[g])); // [R2] [R4] [R5]
        assign latchMask[LO +: GW] = {GW{rxLatch[g]}};
        assign txDecoded[LO +: GW] = r_reg.drv.invFlag[g] ? ~r_reg.drv.data[LO +: GW]
                                                          : r_reg.drv.data[LO +: GW];
    end

    // Our own strobes echo back through the synchroniser; wait until they have drained.
    assign rxArmed = r_reg.drvOeN & (&r_reg.oeHist);
    assign busRise = r_reg.busClkSync[1] & ~r_reg.busClkSync[2];
    assign gotNext = r_reg.rxGot | rxLatch;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        fifoPop = 1'b0;
        startSlot = 1'b0;
        r_next.busClkSync = {r_reg.busClkSync[1:0], busClk};
        r_next.oeHist = {r_reg.oeHist[1:0], r_reg.drvOeN};
        r_next.inS1 = pinsIn;
        r_next.inS2 = r_reg.inS1;
        r_next.prevP = r_reg.inS2.strbP;
        r_next.prevN = r_reg.inS2.strbN;
        r_next.rxValid = 1'b0;
        r_next.rxData = (r_reg.rxData & ~latchMask) | (rxTrue & latchMask); // [R6] [R7]
        if (&gotNext) begin
            r_next.rxWord = r_next.rxData; // [R1]
            r_next.rxValid = 1'b1;
            r_next.rxGot = '0;
        end else begin
            r_next.rxGot = gotNext;
        end

        // A new bus clock period restarts the four slots whenever busOwner is high, which keeps them aligned.
        if (busRise && busOwner) begin
            r_next.slot = '0;
            startSlot = 1'b1; // [R3]
        end else begin
            case (r_reg.phase)
                qpdbi_pkg::PH_IDLE: begin
                    r_next.phase = qpdbi_pkg::PH_IDLE;
                end
                qpdbi_pkg::PH_SETUP: begin
                    r_next.phase = qpdbi_pkg::PH_STROBE;
                    if (!r_reg.drv.valid) begin
                        if (r_reg.slot[0]) begin
                            r_next.drv.strbN = '0; // [R4] [R5]
                        end else begin
                            r_next.drv.strbP = '0; // [R4] [R5]
                        end
                    end
                end
                qpdbi_pkg::PH_STROBE: begin
                    r_next.phase = qpdbi_pkg::PH_HOLD;
                    r_next.holdCnt = 2'(`QPDBI_HOLD_CYC - 1);
                    r_next.drv.strbP = '1;
                    r_next.drv.strbN = '1;
                end
                qpdbi_pkg::PH_HOLD: begin
                    if (r_reg.holdCnt != '0) begin
                        r_next.holdCnt = r_reg.holdCnt - 1'b1;
                    end else if (r_reg.slot == 2'(`QPDBI_SLOTS - 1)) begin
                        r_next.phase = qpdbi_pkg::PH_IDLE;
                        r_next.drvOeN = 1'b1;
                        r_next.drv = '1;
                    end else begin
                        r_next.slot = r_reg.slot + 1'b1;
                        startSlot = 1'b1; // [R3]
                    end
                end
                default: begin
                    r_next.phase = qpdbi_pkg::PH_IDLE;
                end
            endcase
        end

        // An empty buffer leaves the slot unmarked rather than stalling the period.
        if (startSlot) begin
            r_next.phase = qpdbi_pkg::PH_SETUP;
            r_next.holdCnt = '0;
            r_next.drvOeN = 1'b0; // [R1]
            r_next.drv.strbP = '1;
            r_next.drv.strbN = '1;
            r_next.drv.valid = ~fifoValid; // [R2]
            fifoPop = fifoValid;
            r_next.drv.data = txPins;
            r_next.drv.invFlag = ~txInv; // [R9]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '{drv: '1, drvOeN: 1'b1, phase: qpdbi_pkg::PH_IDLE,
                       oeHist: '1, inS1: '1, inS2: '1, prevP: '1, prevN: '1,
                       default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign pinsOut = r_reg.drv;
    assign pinsOeN = r_reg.drvOeN;
    assign rxWord = r_reg.rxWord;
    assign rxValid = r_reg.rxValid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_bus_driven: assert property ( // [R1]
        r_reg.phase != qpdbi_pkg::PH_IDLE |-> !r_reg.drvOeN)
        else $error("Data path not driven during a slot.");

    a_valid_marks: assert property ( // [R2]
        $rose(r_reg.phase == qpdbi_pkg::PH_SETUP) || (r_reg.phase == qpdbi_pkg::PH_SETUP
        && $past(r_reg.phase) != qpdbi_pkg::PH_SETUP) |-> r_reg.drv.valid == !$past(fifoPop))
        else $error("Valid indicator does not match the popped word.");

    a_four_slots: assert property ( // [R3]
        busRise && busOwner |=> r_reg.slot == 2'h0 ##SC r_reg.slot == 2'h1
        ##SC r_reg.slot == 2'h2 ##SC r_reg.slot == 2'h3)
        else $error("Four transfers not placed within one bus period.");

    a_strobe_pair: assert property ( // [R4]
        r_reg.phase == qpdbi_pkg::PH_STROBE && !r_reg.drv.valid
        |-> (r_reg.slot[0] ? (r_reg.drv.strbN == '0 && r_reg.drv.strbP == '1)
                           : (r_reg.drv.strbP == '0 && r_reg.drv.strbN == '1)))
        else $error("Wrong strobe phase for this slot.");

    a_group_word: assert property ( // [R5]
        r_reg.rxValid |-> $past(rxLatch != '0))
        else $error("Word delivered without a strobe edge.");

    a_rx_restore: assert property ( // [R7]
        rxLatch[3] && r_reg.inS2.invFlag[3] |=>
        r_reg.rxData[63:48] == ~$past(r_reg.inS2.data[63:48]))
        else $error("Upper group not restored from the pins.");

    a_lines_limited: assert property ( // [R8]
        r_reg.phase == qpdbi_pkg::PH_SETUP |-> $countones(~r_reg.drv.data[47:32]) <= 8)
        else $error("More than half of a group asserted.");

    a_flag_exact: assert property ( // [R9]
        $past(fifoPop) |-> (!r_reg.drv.invFlag[1]) == ($countones($past(fifoData[31:16])) > 8))
        else $error("Inversion flag does not follow the decision.");

    a_word_intact: assert property ( // [R10]
        $past(fifoPop) |-> txDecoded == $past(fifoData))
        else $error("Driven word does not decode to the popped word.");

    a_group_map: assert property ( // [R6]
        rxLatch[0] && !r_reg.inS2.invFlag[0] |=>
        r_reg.rxData[15:0] == $past(r_reg.inS2.data[15:0]))
        else $error("Lowest group not taken from its own lines.");

    // ----------------------------------------------------------------
    // Slot framing checks
    // ----------------------------------------------------------------
    // A strobe that lingers into the next slot would latch the wrong word at the far side.
    a_strobe_quiet: assert property ( // [R4]
        r_reg.phase != qpdbi_pkg::PH_STROBE |-> (&r_reg.drv.strbP) && (&r_reg.drv.strbN))
        else $error("Strobe low outside the strobe phase.");

    a_empty_quiet: assert property ( // [R2]
        r_reg.phase == qpdbi_pkg::PH_STROBE && r_reg.drv.valid
        |-> (&r_reg.drv.strbP) && (&r_reg.drv.strbN))
        else $error("Strobe pulsed in an unmarked slot.");

    a_idle_release: assert property ( // [R1]
        r_reg.phase == qpdbi_pkg::PH_IDLE |-> r_reg.drvOeN && r_reg.drv == '1)
        else $error("Pins not released while idle.");

    a_slot_steady: assert property ( // [R3]
        r_reg.phase == qpdbi_pkg::PH_STROBE |-> $stable(r_reg.drv.data)
        && $stable(r_reg.drv.invFlag) && $stable(r_reg.drv.valid))
        else $error("Word changed under its strobe.");

    a_strobe_next: assert property ( // [R3]
        r_reg.phase == qpdbi_pkg::PH_STROBE
        |=> r_reg.phase == qpdbi_pkg::PH_HOLD || r_reg.phase == qpdbi_pkg::PH_SETUP)
        else $error("Strobe phase not followed by hold or a new slot.");

    a_pop_slot: assert property ( // [R2]
        fifoPop |-> startSlot && fifoValid)
        else $error("Word popped outside a slot start.");

    a_start_drives: assert property ( // [R1]
        startSlot |=> r_reg.phase == qpdbi_pkg::PH_SETUP && !r_reg.drvOeN)
        else $error("Slot start did not drive the data path.");

    a_upper_flag: assert property ( // [R9]
        $past(fifoPop) |-> (!r_reg.drv.invFlag[3])
        == ($countones($past(fifoData[63:48])) > `QPDBI_HALF_W))
        else $error("Upper inversion flag does not follow the decision.");

    a_upper_pins: assert property ( // [R6]
        $past(fifoPop) && r_reg.drv.invFlag[3]
        |-> r_reg.drv.data[63:48] == ~$past(fifoData[63:48]))
        else $error("Upper group pins not the complement of its word.");

    // ----------------------------------------------------------------
    // Receive checks
    // ----------------------------------------------------------------
    // Our own strobes echo into the receiver, so no word may appear while we drive.
    a_rx_quiet: assert property ( // [R2]
        !r_reg.drvOeN |=> !r_reg.rxValid)
        else $error("Word delivered while this agent drives.");

    a_word_held: assert property ( // [R2]
        !r_reg.rxValid |-> $stable(r_reg.rxWord))
        else $error("Received word changed without a valid pulse.");

    a_unmarked_skip: assert property ( // [R2]
        r_reg.inS2.valid |-> rxLatch == '0)
        else $error("Strobe taken while the valid indicator is negated.");

    c_full_burst: cover property (r_reg.slot == 2'h3 && r_reg.phase == qpdbi_pkg::PH_STROBE
                                  && !r_reg.drv.valid);
    c_rx_word: cover property (r_reg.rxValid);
    c_inverted: cover property (r_reg.phase == qpdbi_pkg::PH_SETUP && !r_reg.drv.invFlag[2]);
    c_empty_slot: cover property (r_reg.phase == qpdbi_pkg::PH_SETUP && r_reg.drv.valid);
    c_restart: cover property (busRise && busOwner && r_reg.phase == qpdbi_pkg::PH_HOLD);

endmodule // qpdbi_link

/* File: qpdbi_pkg.sv */
`include "qpdbi_cfg.svh"

package qpdbi_pkg;

    // Electrical pin levels; every line is asserted when low.
    typedef struct packed {
        logic [`QPDBI_DATA_W-1:0] data;
        logic [`QPDBI_GROUPS-1:0] invFlag;
        logic [`QPDBI_GROUPS-1:0] strbP;
        logic [`QPDBI_GROUPS-1:0] strbN;
        logic valid;
    } qpdbi_pins_t;

    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_SETUP = 4'h2,
        PH_STROBE = 4'h4,
        PH_HOLD = 4'h8
    } qpdbi_phase_t;

    typedef struct packed {
        qpdbi_pins_t drv;
        logic drvOeN;
        qpdbi_phase_t phase;
        logic [1:0] slot;
        logic [1:0] holdCnt;
        logic [2:0] busClkSync;
        logic [2:0] oeHist;
        qpdbi_pins_t inS1;
        qpdbi_pins_t inS2;
        logic [`QPDBI_GROUPS-1:0] prevP;
        logic [`QPDBI_GROUPS-1:0] prevN;
        logic [`QPDBI_DATA_W-1:0] rxData;
        logic [`QPDBI_GROUPS-1:0] rxGot;
        logic [`QPDBI_DATA_W-1:0] rxWord;
        logic rxValid;
    } qpdbi_state_t;

endpackage

/* File: tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [63:0] word;
        logic [3:0] flagPin;
    } qpdbi_row_t;

    logic clk, resetn, busClk, busOwner, txValid, txReady, pinsOeN, rxValid;
    logic [63:0] txData, rxWord;
    qpdbi_pkg::qpdbi_pins_t pinsIn, pinsOut;
    int err_total = 0;
    int cmp_count = 0;
    logic [3:0] prvP = 4'hf;
    logic [3:0] prvN = 4'hf;
    logic [63:0] monData[$];
    logic [12:0] monCtl[$];
    // Group counts 0, 16, 8 and 9 sit on both sides of the more-than-half threshold.
    qpdbi_row_t rows[4] = '{
        '{64'h01ff_00ff_ffff_0000, 4'h5},
        '{64'h0000_ffff_00ff_01ff, 4'ha},
        '{64'h0000_0000_0000_0000, 4'hf},
        '{64'hfffe_7fff_0001_8000, 4'h3}};

    qpdbi_far_agent i_far();
    assign pinsIn = (pinsOeN === 1'b0) ? pinsOut : i_far.drv;

    qpdbi_link i_dut (.clk(clk), .resetn(resetn), .busClk(busClk), .busOwner(busOwner),
        .txValid(txValid), .txData(txData), .txReady(txReady), .pinsIn(pinsIn),
        .pinsOut(pinsOut), .pinsOeN(pinsOeN), .rxWord(rxWord), .rxValid(rxValid));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        busClk = 1'b0;
        #7;
        forever #24 busClk = ~busClk;
    end

    always @(negedge clk) begin
        if (pinsOeN === 1'b0 && ((prvP === 4'hf && pinsOut.strbP !== 4'hf) ||
                (prvN === 4'hf && pinsOut.strbN !== 4'hf))) begin
            monData.push_back(pinsOut.data);
            monCtl.push_back({pinsOut.valid, pinsOut.invFlag, pinsOut.strbP, pinsOut.strbN});
        end
        prvP <= pinsOut.strbP;
        prvN <= pinsOut.strbN;
    end

    task automatic complete_run();
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_up();
        err_total++;
        complete_run();
    endtask

    task automatic push(input logic [63:0] w);
        int k;
        for (k = 0; k < 20 && txReady !== 1'b1; k++) @(negedge clk);
        if (k == 20) give_up();
        txValid = 1'b1;
        txData = w;
        @(negedge clk);
    endtask

    // Holds ownership until n words were strobed out, then lets the bus fall idle.
    task automatic own(input int n);
        int k;
        busOwner = 1'b1;
        for (k = 0; k < 300; k++) begin
            @(negedge clk);
            if (monData.size() >= n && pinsOeN === 1'b0) break;
        end
        if (k == 300) give_up();
        busOwner = 1'b0;
        repeat (40) @(negedge clk);
    endtask

    task automatic wait_rx(input logic [63:0] w);
        int k;
        // Start one edge late so that the pulse of the word before is not taken again.
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            if (rxValid === 1'b1) break;
        end
        if (k == 40) give_up();
        check("rxWord", rxWord, w);
    endtask

    initial begin
        qpdbi_row_t r;
        logic [3:0] fp;
        int hits;
        resetn = 1'b0;
        busOwner = 1'b0;
        txValid = 1'b0;
        txData = '0;
        repeat (5) @(negedge clk);
        check("pinsOut reset", pinsOut, {77{1'b1}});
        check("reset outputs", {pinsOeN, rxValid, txReady, rxWord}, {3'b100, 64'h0});
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            r = rows[i % 4];
            fp = (i < 4) ? r.flagPin : ~r.flagPin;
            fork
                i_far.send(r.word, fp, 1'b0);
                wait_rx(r.word);
            join
        end
        hits = 0;
        fork
            i_far.send(64'h1111_2222_3333_4444, 4'hf, 1'b1);
            repeat (12) @(negedge clk) hits += (rxValid === 1'b1);
        join
        check("rxValid unmarked", hits, 0);
        i_far.release_bus();
        for (int i = 0; i < 8; i++) push(rows[i % 4].word);
        txValid = 1'b0;
        check("txReady full", txReady, 1'b0);
        txValid = 1'b1;
        txData = 64'h5a5a_5a5a_5a5a_5a5a;
        repeat (3) @(negedge clk);
        txValid = 1'b0;
        own(5);
        check("sent count", monData.size(), 8);
        for (int i = 0; i < 8; i++) begin
            r = rows[i % 4];
            check("pin data", monData[i], i_far.enc(r.word, r.flagPin));
            check("pin ctl", monCtl[i], {1'b0, r.flagPin, i[0] ? 8'hf0 : 8'h0f});
        end
        own(8);
        check("empty slots", monData.size(), 8);
        check("idle pins", {pinsOeN, pinsOut}, {78{1'b1}});
        push(rows[0].word);
        txValid = 1'b0;
        busOwner = 1'b1;
        for (hits = 0; hits < 100 && pinsOeN !== 1'b0; hits++) @(negedge clk);
        if (hits == 100) give_up();
        resetn = 1'b0;
        #1;
        check("reset mid", {pinsOeN, txReady, rxValid, pinsOut}, {3'b100, 77'h0 - 1'b1});
        busOwner = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        i_far.release_bus();
        @(negedge clk);
        check("reset release", {pinsOeN, txReady, rxValid, pinsOut}, {3'b110, {77{1'b1}}});
        fork
            i_far.send(rows[3].word, rows[3].flagPin, 1'b0);
            wait_rx(rows[3].word);
        join
        complete_run();
    end
endmodule // tb
